/* File: core/fpccs_pkg.sv */
// Summary of operation
// - Decode primary opcode 0x32, A and B fields, 3 pair-offset bits, 8-bit secondary.
// - Single unordered-or-less-equal compare sets flag on NaN or first <= second.
// - Unordered-or-less-than compares set flag on NaN or first < second.
// - Unordered compares set flag only when an operand is NaN.
// - Compares write the compare flag; single forms test low 32 operand bits.
// - Any compare with an infinite input sets the infinity status bit.
// - On 32-bit machines double operands join a register pair, first is high.
// - Single-to-double convert of low 32 bits, 64-bit result, never an exception.
// - Double subtract writes first minus second, may raise an exception.
// - Single subtract writes low 32 bits; 64-bit machines put ones above.
// - Bits 10, 9, 8 pick plus two or plus one for pair partners.
package fpccs_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int INSN_W = 32;
    localparam int AW = 5;
    localparam int DW = 64;
    localparam int SW = 32;
    localparam int EXC_W = 4;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam logic [5:0] PRIMARY_OPC = 6'h32;
    localparam int PRIM_LSB = 26;
    localparam int D_LSB = 21;
    localparam int A_LSB = 16;
    localparam int B_LSB = 11;
    localparam int OFS_D_BIT = 10;
    localparam int OFS_A_BIT = 9;
    localparam int OFS_B_BIT = 8;

    // ------------------------------------------------------------
    // Secondary opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_ULE_S = 8'h2d;
    localparam logic [7:0] SEC_ULT_D = 8'h3c;
    localparam logic [7:0] SEC_ULT_S = 8'h2c;
    localparam logic [7:0] SEC_UN_D = 8'h3e;
    localparam logic [7:0] SEC_UN_S = 8'h2b;
    localparam logic [7:0] SEC_STOD = 8'h34;
    localparam logic [7:0] SEC_SUB_D = 8'h11;
    localparam logic [7:0] SEC_SUB_S = 8'h01;

    // ------------------------------------------------------------
    // Values and exception bit positions
    // ------------------------------------------------------------
    localparam logic [31:0] NAN_BOX = 32'hffffffff;
    localparam logic [10:0] EXP_BIAS_DIFF = 11'h380;
    localparam int EXC_INVALID = 0;
    localparam int EXC_OVERFLOW = 1;
    localparam int EXC_UNDERFLOW = 2;
    localparam int EXC_INEXACT = 3;
    localparam int LATENCY_CYCLES = 1;

    typedef struct packed {
        logic done;
        logic unhandled;
        logic flag_we;
        logic flag;
        logic inf_set;
        logic [EXC_W-1:0] exc;
        logic wr_en;
        logic wr_pair;
        logic [AW-1:0] wr_a1;
        logic [AW-1:0] wr_a2;
        logic [DW-1:0] wr_data;
    } fpccs_state_s;

    localparam fpccs_state_s STATE_RST = '0;

endpackage

/* File: core/fpccs_opnd_if.sv */
`timescale 1ns/1ps
interface fpccs_opnd_if #(parameter int W = 32);
    logic [W-1:0] a;
    logic [W-1:0] b;
    modport source(output a, output b);
    modport sink(input a, input b);
endinterface

/* File: core/fpccs_cmp.sv */
`timescale 1ns/1ps
module fpccs_cmp #(
    parameter int EW = 8,
    parameter int MW = 23
) (
    // Operands
    fpccs_opnd_if.sink opnd,
    // Relations
    output logic unord_o,
    output logic lt_o,
    output logic eq_o,
    output logic inf_o
);
    localparam int N = EW + MW + 1;
    logic [N-1:0] a;
    logic [N-1:0] b;
    logic nan_a, nan_b, both_zero;

    assign a = opnd.a[N-1:0];
    assign b = opnd.b[N-1:0];
    assign nan_a = (&a[N-2:MW]) & (|a[MW-1:0]);
    assign nan_b = (&b[N-2:MW]) & (|b[MW-1:0]);
    assign inf_o = ((&a[N-2:MW]) & ~(|a[MW-1:0])) | ((&b[N-2:MW]) & ~(|b[MW-1:0]));
    assign unord_o = nan_a | nan_b;
    assign both_zero = ~(|a[N-2:0]) & ~(|b[N-2:0]);

    assign eq_o = ~unord_o & ((a == b) | both_zero);

    always_comb begin
        lt_o = 1'b0;
        if (unord_o || both_zero) begin
            lt_o = 1'b0;
        end else if (a[N-1] != b[N-1]) begin
            lt_o = a[N-1];
        end else if (!a[N-1]) begin
            lt_o = a[N-2:0] < b[N-2:0];
        end else begin
            lt_o = a[N-2:0] > b[N-2:0];
        end
    end
endmodule

/* File: core/fpccs_sub.sv */
`timescale 1ns/1ps
module fpccs_sub #(
    parameter int EW = 8,
    parameter int MW = 23
) (
    // Operands
    fpccs_opnd_if.sink opnd,
    // Result
    output logic [EW+MW:0] diff_o,
    output logic [3:0] exc_o
);
    localparam int N = EW + MW + 1;
    localparam int W = MW + 4;
    localparam int EMAX = (1 << EW) - 1;
    localparam logic [N-1:0] QNAN = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};

    // Round to nearest even only; no dynamic rounding mode
    always_comb begin
        logic [N-1:0] a, b, x, y;
        logic [W:0] mx, my, sum, mask;
        logic [MW+1:0] rnd;
        logic [MW-1:0] frac;
        logic nan_a, nan_b, inf_a, inf_b, eff_sub, g, st, zero;
        int ex, ey, d, lz, s, e;
        frac = '0;
        a = opnd.a[N-1:0];
        b = {~opnd.b[N-1], opnd.b[N-2:0]};
        nan_a = (&a[N-2:MW]) & (|a[MW-1:0]);
        nan_b = (&b[N-2:MW]) & (|b[MW-1:0]);
        inf_a = (&a[N-2:MW]) & ~(|a[MW-1:0]);
        inf_b = (&b[N-2:MW]) & ~(|b[MW-1:0]);
        eff_sub = a[N-1] ^ b[N-1];
        x = (a[N-2:0] >= b[N-2:0]) ? a : b;
        y = (a[N-2:0] >= b[N-2:0]) ? b : a;
        ex = (x[N-2:MW] == '0) ? 1 : int'(x[N-2:MW]);
        ey = (y[N-2:MW] == '0) ? 1 : int'(y[N-2:MW]);
        mx = {1'b0, |x[N-2:MW], x[MW-1:0], 3'h0};
        my = {1'b0, |y[N-2:MW], y[MW-1:0], 3'h0};
        d = ex - ey;
        mask = '1;
        st = 1'b0;
        // Sticky keeps the far shifted bits alive for rounding
        if (d > W) begin
            my = {{W{1'b0}}, |my};
        end else begin
            mask = ~(mask << d);
            st = |(my & mask);
            my = my >> d;
            my[0] = my[0] | st;
        end
        sum = eff_sub ? (mx - my) : (mx + my);
        e = ex;
        lz = W;
        s = 0;
        if (sum[W]) begin
            sum = {1'b0, sum[W:2], sum[1] | sum[0]};
            e = e + 1;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (sum[i]) begin
                    lz = W - 1 - i;
                end
            end
            s = (lz < e - 1) ? lz : e - 1;
            sum = sum << s;
            e = e - s;
            if (!sum[W-1]) begin
                e = 0;
            end
        end
        zero = (sum == '0);
        g = sum[2];
        st = sum[1] | sum[0];
        rnd = {1'b0, sum[W-1:3]} + {{(MW+1){1'b0}}, g & (st | sum[3])};
        if (rnd[MW+1]) begin
            e = e + 1;
            frac = rnd[MW:1];
        end else begin
            if (e == 0 && rnd[MW]) begin
                e = 1;
            end
            frac = rnd[MW-1:0];
        end
        exc_o = 4'h0;
        if (nan_a || nan_b) begin
            diff_o = QNAN;
            exc_o[0] = (nan_a & ~a[MW-1]) | (nan_b & ~b[MW-1]);
        end else if (inf_a && inf_b && eff_sub) begin
            diff_o = QNAN;
            exc_o[0] = 1'b1;
        end else if (inf_a || inf_b) begin
            diff_o = {inf_a ? a[N-1] : b[N-1], {EW{1'b1}}, {MW{1'b0}}};
        end else if (zero) begin
            diff_o = {eff_sub ? 1'b0 : x[N-1], {(N-1){1'b0}}};
        end else if (e >= EMAX) begin
            diff_o = {x[N-1], {EW{1'b1}}, {MW{1'b0}}};
            exc_o = 4'ha;
        end else begin
            diff_o = {x[N-1], EW'(e), frac};
            exc_o[2] = (e == 0) & (g | st);
            exc_o[3] = g | st;
        end
    end
endmodule

/* File: core/fpccs_unit.sv */
`timescale 1ns/1ps
module fpccs_unit #(
    parameter bit IS_64BIT = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Issue
    input wire logic issue_valid_i,
    input wire logic [fpccs_pkg::INSN_W-1:0] insn_i,
    // Register read addresses
    output logic [fpccs_pkg::AW-1:0] rd_addr_a1_o,
    output logic [fpccs_pkg::AW-1:0] rd_addr_a2_o,
    output logic [fpccs_pkg::AW-1:0] rd_addr_b1_o,
    output logic [fpccs_pkg::AW-1:0] rd_addr_b2_o,
    // Operand data
    input wire logic [fpccs_pkg::DW-1:0] src_a1_i,
    input wire logic [fpccs_pkg::DW-1:0] src_a2_i,
    input wire logic [fpccs_pkg::DW-1:0] src_b1_i,
    input wire logic [fpccs_pkg::DW-1:0] src_b2_i,
    // Completion
    output logic done_o,
    output logic unhandled_o,
    // Flag and status
    output logic flag_we_o,
    output logic compare_flag_o,
    output logic fp_infinity_status_bit_o,
    output logic [fpccs_pkg::EXC_W-1:0] fp_exc_o,
    // Register write-back
    output logic wr_en_o,
    output logic wr_pair_o,
    output logic [fpccs_pkg::AW-1:0] wr_addr1_o,
    output logic [fpccs_pkg::AW-1:0] wr_addr2_o,
    output logic [fpccs_pkg::DW-1:0] wr_data_o
);
    import fpccs_pkg::*;

    // ------------------------------------------------------------
    // Decode and operands
    // ------------------------------------------------------------
    fpccs_state_s st;
    fpccs_state_s next_st;
    logic is_fp;
    logic [7:0] sec;
    logic [AW-1:0] d1, d2;
    logic [DW-1:0] dp_a, dp_b;
    logic [SW-1:0] sp_a, sp_b;
    logic s_unord, s_lt, s_eq, s_inf;
    logic d_unord, d_lt, d_eq, d_inf;
    logic [SW-1:0] s_diff;
    logic [DW-1:0] d_diff;
    logic [3:0] s_exc, d_exc;
    logic [DW-1:0] stod_res;

    assign is_fp = issue_valid_i && (insn_i[INSN_W-1:PRIM_LSB] == PRIMARY_OPC);
    assign sec = insn_i[7:0];

    assign rd_addr_a1_o = insn_i[A_LSB+AW-1:A_LSB];
    assign rd_addr_b1_o = insn_i[B_LSB+AW-1:B_LSB];
    assign d1 = insn_i[D_LSB+AW-1:D_LSB];
    assign rd_addr_a2_o = IS_64BIT ? rd_addr_a1_o : AW'(rd_addr_a1_o + (insn_i[OFS_A_BIT] ? 5'h2 : 5'h1));
    assign rd_addr_b2_o = IS_64BIT ? rd_addr_b1_o : AW'(rd_addr_b1_o + (insn_i[OFS_B_BIT] ? 5'h2 : 5'h1));
    assign d2 = IS_64BIT ? d1 : AW'(d1 + (insn_i[OFS_D_BIT] ? 5'h2 : 5'h1));

    assign dp_a = IS_64BIT ? src_a1_i : {src_a1_i[SW-1:0], src_a2_i[SW-1:0]};
    assign dp_b = IS_64BIT ? src_b1_i : {src_b1_i[SW-1:0], src_b2_i[SW-1:0]};
    assign sp_a = src_a1_i[SW-1:0];
    assign sp_b = src_b1_i[SW-1:0];

    // ------------------------------------------------------------
    // Arithmetic units
    // ------------------------------------------------------------
    fpccs_opnd_if #(.W(SW)) sp_opnd();
    fpccs_opnd_if #(.W(DW)) dp_opnd();
    assign sp_opnd.a = sp_a;
    assign sp_opnd.b = sp_b;
    assign dp_opnd.a = dp_a;
    assign dp_opnd.b = dp_b;

    fpccs_cmp #(.EW(8), .MW(23)) u_cmp_s (
        .opnd(sp_opnd),
        .unord_o(s_unord),
        .lt_o(s_lt),
        .eq_o(s_eq),
        .inf_o(s_inf)
    );

    fpccs_cmp #(.EW(11), .MW(52)) u_cmp_d (
        .opnd(dp_opnd),
        .unord_o(d_unord),
        .lt_o(d_lt),
        .eq_o(d_eq),
        .inf_o(d_inf)
    );

    fpccs_sub #(.EW(8), .MW(23)) u_sub_s (
        .opnd(sp_opnd),
        .diff_o(s_diff),
        .exc_o(s_exc)
    );

    fpccs_sub #(.EW(11), .MW(52)) u_sub_d (
        .opnd(dp_opnd),
        .diff_o(d_diff),
        .exc_o(d_exc)
    );

    // Widening is exact, so no rounding and no exception path
    function automatic logic [DW-1:0] fpccs_stod(input logic [SW-1:0] s);
        logic [7:0] e;
        logic [22:0] m;
        logic [22:0] mm;
        logic [DW-1:0] r;
        int lz;
        e = s[30:23];
        m = s[22:0];
        r = {s[31], 63'h0};
        lz = 0;
        mm = 23'h0;
        if (e == 8'hff) begin
            r = {s[31], 11'h7ff, (m == 23'h0) ? 52'h0 : {1'b1, m[21:0], 29'h0}};
        end else if (e != 8'h0) begin
            r = {s[31], {3'h0, e} + EXP_BIAS_DIFF, m, 29'h0};
        end else if (m != 23'h0) begin
            for (int i = 0; i < 23; i++) begin
                if (m[i]) begin
                    lz = 22 - i;
                end
            end
            mm = 23'(m << (lz + 1));
            r = {s[31], 11'(int'(EXP_BIAS_DIFF) - lz), mm, 29'h0};
        end
        return r;
    endfunction

    assign stod_res = fpccs_stod(sp_a);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.unhandled = 1'b0;
        next_st.flag_we = 1'b0;
        next_st.inf_set = 1'b0;
        next_st.exc = '0;
        next_st.wr_en = 1'b0;
        if (is_fp) begin
            next_st.done = 1'b1;
            next_st.wr_a1 = d1;
            next_st.wr_a2 = d2;
            next_st.wr_pair = 1'b0;
            case (sec)
                SEC_ULE_S: begin
                    next_st.flag_we = 1'b1;
                    next_st.flag = s_unord | s_lt | s_eq;
                    next_st.inf_set = s_inf;
                end
                SEC_ULT_D: begin
                    next_st.flag_we = 1'b1;
                    next_st.flag = d_unord | d_lt;
                    next_st.inf_set = d_inf;
                end
                SEC_ULT_S: begin
                    next_st.flag_we = 1'b1;
                    next_st.flag = s_unord | s_lt;
                    next_st.inf_set = s_inf;
                end
                SEC_UN_D: begin
                    next_st.flag_we = 1'b1;
                    next_st.flag = d_unord;
                    next_st.inf_set = d_inf;
                end
                SEC_UN_S: begin
                    next_st.flag_we = 1'b1;
                    next_st.flag = s_unord;
                    next_st.inf_set = s_inf;
                end
                SEC_STOD: begin
                    next_st.wr_en = 1'b1;
                    next_st.wr_pair = !IS_64BIT;
                    next_st.wr_data = stod_res;
                end
                SEC_SUB_D: begin
                    next_st.wr_en = 1'b1;
                    next_st.wr_pair = !IS_64BIT;
                    next_st.wr_data = d_diff;
                    next_st.exc = d_exc;
                end
                SEC_SUB_S: begin
                    next_st.wr_en = 1'b1;
                    next_st.wr_data = {IS_64BIT ? NAN_BOX : 32'h0, s_diff};
                    next_st.exc = s_exc;
                end
                default: begin
                    next_st.done = 1'b0;
                    next_st.unhandled = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign done_o = st.done;
    assign unhandled_o = st.unhandled;
    assign flag_we_o = st.flag_we;
    assign compare_flag_o = st.flag;
    assign fp_infinity_status_bit_o = st.inf_set;
    assign fp_exc_o = st.exc;
    assign wr_en_o = st.wr_en;
    assign wr_pair_o = st.wr_pair;
    assign wr_addr1_o = st.wr_a1;
    assign wr_addr2_o = st.wr_a2;
    assign wr_data_o = st.wr_data;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    logic is_cmp;
    assign is_cmp = is_fp && (sec == SEC_ULE_S || sec == SEC_ULT_D || sec == SEC_ULT_S ||
                              sec == SEC_UN_D || sec == SEC_UN_S);

    AST_NOT_FP: assert property (issue_valid_i && !is_fp |=> !done_o && !unhandled_o && !wr_en_o)
        else $error("foreign instruction produced a result");
    AST_ULE_POS: assert property (is_fp && sec == SEC_ULE_S && !sp_a[31] && !sp_b[31] &&
        sp_a[30:23] != 8'hff && sp_b[30:23] != 8'hff && sp_a[30:0] <= sp_b[30:0]
        |=> flag_we_o && compare_flag_o)
        else $error("less-equal compare missed a true case");
    AST_ULE_NAN: assert property (is_fp && sec == SEC_ULE_S && (&sp_a[30:23]) && (|sp_a[22:0])
        |=> compare_flag_o)
        else $error("less-equal compare ignored NaN");
    AST_ULT_NEG: assert property (is_fp && sec == SEC_ULT_D && dp_a[63] && dp_b[63] &&
        dp_a[62:52] != 11'h7ff && dp_b[62:52] != 11'h7ff && dp_a[62:0] > dp_b[62:0]
        |=> compare_flag_o)
        else $error("negative less-than compare wrong");
    AST_ULT_EQ: assert property (is_fp && sec == SEC_ULT_S && sp_a == sp_b && sp_a[30:23] != 8'hff
        |=> flag_we_o && !compare_flag_o)
        else $error("less-than set on equal operands");
    AST_UN_ZERO: assert property (is_fp && sec == SEC_UN_D && dp_a == 64'h0 && dp_b == 64'h0
        |=> flag_we_o && !compare_flag_o)
        else $error("unordered compare set on zeros");
    AST_CMP_DEST: assert property (is_cmp |=> flag_we_o && !wr_en_o && fp_exc_o == 4'h0)
        else $error("compare wrote a register");
    AST_INF: assert property (is_fp && sec == SEC_UN_S && sp_a == 32'h7f800000
        |=> fp_infinity_status_bit_o)
        else $error("infinite input not reported");
    AST_INF_ONLY_CMP: assert property (issue_valid_i && !is_cmp |=> !fp_infinity_status_bit_o)
        else $error("infinity status from non-compare");
    AST_DP_JOIN: assert property (!IS_64BIT && is_fp && sec == SEC_SUB_D && dp_b == 64'h0 &&
        src_a1_i[30:20] != 11'h0 && src_a1_i[30:20] != 11'h7ff
        |=> wr_data_o == {$past(src_a1_i[31:0]), $past(src_a2_i[31:0])})
        else $error("register pair joined wrongly");
    AST_STOD_ONE: assert property (is_fp && sec == SEC_STOD && sp_a == 32'h3f800000
        |=> wr_en_o && wr_data_o == 64'h3ff0000000000000 && fp_exc_o == 4'h0)
        else $error("widening of one is wrong");
    AST_SUBD_ZERO: assert property (is_fp && sec == SEC_SUB_D && dp_b == 64'h0 &&
        dp_a[62:52] != 11'h0 && dp_a[62:52] != 11'h7ff
        |=> wr_en_o && wr_data_o == $past(dp_a) && fp_exc_o == 4'h0)
        else $error("subtracting zero changed the value");
    AST_SUBS_BOX: assert property (is_fp && sec == SEC_SUB_S
        |=> wr_en_o && !wr_pair_o && wr_data_o[63:32] == (IS_64BIT ? NAN_BOX : 32'h0))
        else $error("single result upper half wrong");
    AST_PAIR: assert property (!IS_64BIT && is_fp && sec == SEC_STOD
        |=> wr_pair_o && wr_addr2_o == AW'(wr_addr1_o + ($past(insn_i[OFS_D_BIT]) ? 5'h2 : 5'h1)))
        else $error("destination partner wrong");
    AST_ZERO_EQ: assert property (is_fp && sec == SEC_ULE_S && sp_a == 32'h80000000 && sp_b == 32'h0
        |=> compare_flag_o)
        else $error("signed zeros not equal");

    COV_ULE_SET: cover property (is_fp && sec == SEC_ULE_S ##1 compare_flag_o);
    COV_SUBD_OVF: cover property (wr_en_o && fp_exc_o[EXC_OVERFLOW]);
    COV_STOD: cover property (is_fp && sec == SEC_STOD ##1 wr_en_o);
    COV_UNHANDLED: cover property (unhandled_o);
endmodule

/* File: sim/fpccs_pipe_model.sv */
`timescale 1ns/1ps
module fpccs_pipe_model (
    // Clock and preload
    input wire logic clk_sys_i,
    input wire logic load_en_i,
    input wire logic [fpccs_pkg::AW-1:0] load_addr_i,
    input wire logic [fpccs_pkg::DW-1:0] load_data_i,
    // Register reads
    input wire logic [fpccs_pkg::AW-1:0] rd_a1_i,
    input wire logic [fpccs_pkg::AW-1:0] rd_a2_i,
    input wire logic [fpccs_pkg::AW-1:0] rd_b1_i,
    input wire logic [fpccs_pkg::AW-1:0] rd_b2_i,
    output logic [fpccs_pkg::DW-1:0] src_a1_o,
    output logic [fpccs_pkg::DW-1:0] src_a2_o,
    output logic [fpccs_pkg::DW-1:0] src_b1_o,
    output logic [fpccs_pkg::DW-1:0] src_b2_o
);
    import fpccs_pkg::*;
    // ----
    // Register file
    // ----
    // Never loaded entries stay unknown, so a stray read shows
    logic [DW-1:0] regs [32];
    always_ff @(posedge clk_sys_i) begin
        if (load_en_i) begin
            regs[load_addr_i] <= load_data_i;
        end
    end
    // Same-cycle reads, as the core supplies them
    assign src_a1_o = regs[rd_a1_i];
    assign src_a2_o = regs[rd_a2_i];
    assign src_b1_o = regs[rd_b1_i];
    assign src_b2_o = regs[rd_b2_i];
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import fpccs_pkg::*;
    typedef struct {
        logic [7:0] s;
        logic [63:0] a;
        logic [63:0] b;
        logic c;
        logic f;
        logic i;
        logic [63:0] d;
        logic [3:0] x;
    } fpccs_row_s;
    localparam logic [63:0] S1 = 64'hffffffff3f800000;
    localparam logic [63:0] S2 = 64'hffffffff40000000;
    localparam logic [63:0] SN = 64'hffffffff7fc00000;
    localparam logic [63:0] SI = 64'hffffffff7f800000;
    localparam logic [63:0] D1 = 64'h3ff0000000000000;
    localparam logic [63:0] D2 = 64'h4000000000000000;
    localparam logic [63:0] DN = 64'h7ff8000000000000;
    localparam logic [63:0] DI = 64'h7ff0000000000000;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic issue_valid_i = 1'b0;
    logic [31:0] insn_i = 32'h0;
    logic ld_en = 1'b0;
    logic [4:0] ld_addr = 5'h0;
    logic [63:0] ld_data = 64'h0;
    logic [4:0] ra1, ra2, rb1, rb2, wa1, wa2;
    logic [63:0] sa1, sa2, sb1, sb2, wdata;
    logic done, unh, fwe, flag, infb, wen, wpair;
    logic [3:0] exc;
    logic [4:0] ra1_32, ra2_32, rb1_32, rb2_32, wa1_32, wa2_32;
    logic [63:0] sa1_32, sa2_32, sb1_32, sb2_32, wdata_32;
    logic wen_32, wpair_32;
    int fails = 0;
    int compares = 0;
    fpccs_row_s rows[$];
    always #5 clk_sys_i = ~clk_sys_i;
    fpccs_unit #(.IS_64BIT(1'b1)) dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .issue_valid_i(issue_valid_i), .insn_i(insn_i), .rd_addr_a1_o(ra1), .rd_addr_a2_o(ra2),
        .rd_addr_b1_o(rb1), .rd_addr_b2_o(rb2), .src_a1_i(sa1), .src_a2_i(sa2), .src_b1_i(sb1),
        .src_b2_i(sb2), .done_o(done), .unhandled_o(unh), .flag_we_o(fwe), .compare_flag_o(flag),
        .fp_infinity_status_bit_o(infb), .fp_exc_o(exc), .wr_en_o(wen), .wr_pair_o(wpair),
        .wr_addr1_o(wa1), .wr_addr2_o(wa2), .wr_data_o(wdata));
    fpccs_pipe_model u_pipe (.clk_sys_i(clk_sys_i), .load_en_i(ld_en), .load_addr_i(ld_addr),
        .load_data_i(ld_data), .rd_a1_i(ra1), .rd_a2_i(ra2), .rd_b1_i(rb1), .rd_b2_i(rb2),
        .src_a1_o(sa1), .src_a2_o(sa2), .src_b1_o(sb1), .src_b2_o(sb2));
    // Narrow machine: register pairs
    fpccs_unit #(.IS_64BIT(1'b0)) dut_32 (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .issue_valid_i(issue_valid_i), .insn_i(insn_i), .rd_addr_a1_o(ra1_32), .rd_addr_a2_o(ra2_32),
        .rd_addr_b1_o(rb1_32), .rd_addr_b2_o(rb2_32), .src_a1_i(sa1_32), .src_a2_i(sa2_32),
        .src_b1_i(sb1_32), .src_b2_i(sb2_32), .done_o(), .unhandled_o(), .flag_we_o(), .compare_flag_o(),
        .fp_infinity_status_bit_o(), .fp_exc_o(), .wr_en_o(wen_32), .wr_pair_o(wpair_32),
        .wr_addr1_o(wa1_32), .wr_addr2_o(wa2_32), .wr_data_o(wdata_32));
    fpccs_pipe_model u_pipe_32 (.clk_sys_i(clk_sys_i), .load_en_i(ld_en), .load_addr_i(ld_addr),
        .load_data_i(ld_data), .rd_a1_i(ra1_32), .rd_a2_i(ra2_32), .rd_b1_i(rb1_32), .rd_b2_i(rb2_32),
        .src_a1_o(sa1_32), .src_a2_o(sa2_32), .src_b1_o(sb1_32), .src_b2_o(sb2_32));
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic add(input logic [7:0] s, input logic [63:0] a, b, input logic c, f, i,
        input logic [63:0] d, input logic [3:0] x);
        rows.push_back('{s, a, b, c, f, i, d, x});
    endtask
    task automatic load(input logic [4:0] ad, input logic [63:0] d);
        @(negedge clk_sys_i);
        ld_en = 1'b1;
        ld_addr = ad;
        ld_data = d;
        @(negedge clk_sys_i);
        ld_en = 1'b0;
    endtask
    task automatic issue(input logic [5:0] p, input logic [7:0] s);
        @(negedge clk_sys_i);
        issue_valid_i = 1'b1;
        insn_i = {p, 5'h3, 5'h1, 5'h2, 3'b000, s};
    endtask
    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        #100000;
        fails++;
        $display("MISMATCH watchdog exp end got hang");
        conclude();
    end
    initial begin
        add(SEC_ULE_S, S1, S2, 1, 1, 0, 0, 0);
        add(SEC_ULE_S, S2, S1, 1, 0, 0, 0, 0);
        add(SEC_ULE_S, S1, S1, 1, 1, 0, 0, 0);
        add(SEC_ULE_S, SN, S1, 1, 1, 0, 0, 0);
        add(SEC_ULE_S, SI, S1, 1, 0, 1, 0, 0);
        add(SEC_ULT_S, S1, S1, 1, 0, 0, 0, 0);
        add(SEC_ULT_S, 64'hffffffffc0000000, S1, 1, 1, 0, 0, 0);
        add(SEC_ULT_S, S1, SN, 1, 1, 0, 0, 0);
        add(SEC_ULT_D, D1, D2, 1, 1, 0, 0, 0);
        add(SEC_ULT_D, D2, D1, 1, 0, 0, 0, 0);
        add(SEC_ULT_D, 64'hbff0000000000000, D1, 1, 1, 0, 0, 0);
        add(SEC_ULT_D, D1, DN, 1, 1, 0, 0, 0);
        add(SEC_UN_D, D1, D2, 1, 0, 0, 0, 0);
        add(SEC_UN_D, DN, D1, 1, 1, 0, 0, 0);
        add(SEC_UN_D, DI, D1, 1, 0, 1, 0, 0);
        add(SEC_UN_S, S1, 64'h00000000ffffffff, 1, 1, 0, 0, 0);
        add(SEC_UN_S, S1, S2, 1, 0, 0, 0, 0);
        add(SEC_SUB_D, D2, D1, 0, 0, 0, D1, 0);
        add(SEC_SUB_D, DI, DI, 0, 0, 0, DN, 1);
        add(SEC_SUB_S, S2, S1, 0, 0, 0, S1, 0);
        add(SEC_STOD, 64'ha5a5a5a53f800000, S2, 0, 0, 0, D1, 0);
        repeat (20) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        chk("rst data", 64'h0, wdata);
        chk("rst bits", 64'h0, 64'({done, unh, fwe, flag, infb, wen, exc}));
        foreach (rows[k]) begin
            load(5'h1, rows[k].a);
            load(5'h2, rows[k].b);
            issue(6'h32, rows[k].s);
            @(negedge clk_sys_i);
            issue_valid_i = 1'b0;
            chk("done", 64'h1, 64'(done));
            chk("flag_we", 64'(rows[k].c), 64'(fwe));
            chk("inf", 64'(rows[k].i), 64'(infb));
            chk("wr_en", 64'(!rows[k].c), 64'(wen));
            if (rows[k].c) begin
                chk("flag", 64'(rows[k].f), 64'(flag));
            end else begin
                chk("data", rows[k].d, wdata);
                chk("exc", 64'(rows[k].x), 64'(exc));
                chk("wr dest", 64'h63, 64'({wpair, wa1, wa2}));
            end
        end
        // Back to back, then undecoded and foreign opcodes
        load(5'h1, S1);
        load(5'h2, S2);
        issue(6'h32, SEC_ULT_S);
        #1;
        chk("rd addr", 64'h8442, 64'({ra1, ra2, rb1, rb2}));
        issue(6'h32, SEC_UN_S);
        chk("flag b2b", 64'h1, 64'(flag));
        issue(6'h32, 8'hff);
        chk("flag b2b", 64'h0, 64'(flag));
        issue(6'h05, SEC_ULT_S);
        chk("unhandled", 64'h1, 64'({done, unh}));
        @(negedge clk_sys_i);
        issue_valid_i = 1'b0;
        chk("foreign", 64'h0, 64'({done, unh, fwe, flag}));
        // Pairs {r1,r2} minus {r2,r3}, result to r3 and r4
        load(5'h1, 64'h3ff00000);
        load(5'h2, 64'h0);
        load(5'h3, 64'h0);
        issue(6'h32, SEC_SUB_D);
        #1;
        chk("rd pair", 64'h8843, 64'({ra1_32, ra2_32, rb1_32, rb2_32}));
        @(negedge clk_sys_i);
        issue_valid_i = 1'b0;
        chk("pair data", D1, wdata_32);
        chk("pair dest", 64'hc64, 64'({wen_32, wpair_32, wa1_32, wa2_32}));
        // Reset in mid-run clears held results
        resetn_i = 1'b0;
        @(negedge clk_sys_i);
        chk("mid rst", 64'h0, wdata);
        chk("mid rst 32", 64'h0, wdata_32);
        resetn_i = 1'b1;
        issue(6'h32, SEC_ULE_S);
        @(negedge clk_sys_i);
        issue_valid_i = 1'b0;
        chk("after rst", 64'h2, 64'({fwe, flag}));
        conclude();
    end
endmodule
